// ==== hw/dmc_pkg.sv ====
// shared constants and bus carriers for the dot-matrix character generator
`default_nettype none
package dmc_pkg;
   // ***************************************************************
   // geometry
   // ***************************************************************
   localparam int CODE_W      = 6;
   localparam int DOT_W       = 7;
   localparam int ROW_W       = 4;
   localparam int GLYPH_ROWS  = 9;
   localparam int NUM_GLYPHS  = 64;
   localparam int MEM_DEPTH   = NUM_GLYPHS * GLYPH_ROWS;
   localparam int MEM_AW      = 10;

   // ***************************************************************
   // row counter states, T1 encoded as zero
   // ***************************************************************
   localparam logic [ROW_W-1:0] ST_T1        = 4'h0;
   localparam logic [ROW_W-1:0] ST_T7        = 4'h6;
   localparam logic [ROW_W-1:0] ST_END       = 4'hF;
   localparam logic [ROW_W-1:0] ST_UNDERLINE = 4'hC;
   localparam logic [ROW_W-1:0] ROW_STEP     = 4'h1;
   localparam logic [ROW_W-1:0] WIN_NORMAL   = 4'h3;
   localparam logic [ROW_W-1:0] WIN_SUB      = 4'h6;
   localparam logic [ROW_W-1:0] WIN_SUPER    = 4'h0;
   localparam logic [ROW_W-1:0] GLYPH_LAST   = 4'h8;

   // display mode codes written as {sel_a, sel_b}
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_SUB    = 2'h1;
   localparam logic [1:0] MODE_UNDER  = 2'h2;
   localparam logic [1:0] MODE_SUPER  = 2'h3;

   localparam logic [DOT_W-1:0] DOTS_ONES  = 7'h7F;
   localparam logic [DOT_W-1:0] DOTS_ZEROS = 7'h00;

   // ***************************************************************
   // register map, byte addresses
   // ***************************************************************
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_FADDR  = 8'h08;
   localparam logic [7:0] ADR_FDATA  = 8'h0C;

   // ctrl fields
   localparam int CTRL_CODE_LSB = 0;
   localparam int CTRL_SEL_A    = 6;
   localparam int CTRL_SEL_B    = 7;
   localparam int CTRL_INVERT   = 8;
   localparam int CTRL_CE       = 9;
   localparam logic [9:0] CTRL_RESET = 10'h100;
   // status fields
   localparam int STAT_ROW_LSB = 0;
   localparam int STAT_FLAG    = 4;
   localparam int STAT_OE      = 5;
   localparam int STAT_DOT_LSB = 8;
   // font address fields
   localparam int FADDR_CODE_LSB = 0;
   localparam int FADDR_ROW_LSB  = 8;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } dmc_wb_req_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } dmc_wb_rsp_s;
endpackage
`default_nettype wire

// ==== hw/dmc_glyph_mem.sv ====
// glyph memory: 64 glyphs of nine 7-bit rows, one write and two read ports
`timescale 1ns/1ns
`default_nettype none
module dmc_glyph_mem (
   input  wire logic                         clk_i,
   input  wire logic                         wr_en_i,
   input  wire logic [dmc_pkg::CODE_W-1:0]   wr_code_i,
   input  wire logic [dmc_pkg::ROW_W-1:0]    wr_row_i,
   input  wire logic [dmc_pkg::DOT_W-1:0]    wr_dots_i,
   input  wire logic [dmc_pkg::CODE_W-1:0]   rd_code_i,
   input  wire logic [dmc_pkg::ROW_W-1:0]    rd_row_i,
   output logic      [dmc_pkg::DOT_W-1:0]    rd_dots_o,
   input  wire logic [dmc_pkg::CODE_W-1:0]   bus_code_i,
   input  wire logic [dmc_pkg::ROW_W-1:0]    bus_row_i,
   output logic      [dmc_pkg::DOT_W-1:0]    bus_dots_o
);
   import dmc_pkg::*;

   // rows stored top to bottom, dot seven in the msb, outline as zero
   logic [DOT_W-1:0] mem [0:MEM_DEPTH-1];
   logic [MEM_AW-1:0] wr_idx;
   logic [MEM_AW-1:0] rd_idx;
   logic [MEM_AW-1:0] bus_idx;

   // ***************************************************************
   // index = code * rows + row
   // ***************************************************************
   function automatic logic [MEM_AW-1:0] idx_of(
      input logic [CODE_W-1:0] code,
      input logic [ROW_W-1:0]  row);
      logic [MEM_AW-1:0] base;
      base = MEM_AW'({4'h0, code} * MEM_AW'(GLYPH_ROWS));
      return base + MEM_AW'(row);
   endfunction

   assign wr_idx  = idx_of(wr_code_i, wr_row_i);
   assign rd_idx  = idx_of(rd_code_i, rd_row_i);
   assign bus_idx = idx_of(bus_code_i, bus_row_i);

   // font load; row numbers beyond the glyph are dropped
   always_ff @(posedge clk_i) begin
      if (wr_en_i && (wr_row_i <= GLYPH_LAST)) begin
         mem[wr_idx] <= wr_dots_i;
      end
   end

   // reads are combinational so the row appears as soon as the code settles
   assign rd_dots_o  = mem[rd_idx];
   assign bus_dots_o = (bus_row_i <= GLYPH_LAST) ? mem[bus_idx] : DOTS_ZEROS;
endmodule // dmc_glyph_mem
`default_nettype wire

// ==== hw/dmc_top.sv ====
// character generator core: row counter, display windows, wishbone registers
//
// Operation
// - six-bit code selects one of 64 glyphs
// - selected row appears on seven dot outputs
// - modulo-16 row counter steps once per pulse
// - both resets high: counter wraps freely
// - stop reset low: counter stops at last row
// - stop released: T1 follows next pulse
// - preset reset low forces T7 at once
// - mode bits may change per character
// - mode picks window: normal, underline, sub, super
// - flag high at last row, low at T1/T7
// - invert high: glyph zeros on ones
// - chip enable floats dot outputs when off
// - last-row flag is never floated
// - updates follow falling edge of step pulse
// - enabling level of chip enable is option
// - glyph is nine rows, msb dot seven
// - memory holds outline zero, background one
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module dmc_top #(
   parameter logic CE_ENABLE_LEVEL = 1'b1
) (
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire dmc_pkg::dmc_wb_req_s         wb_req_i,
   output dmc_pkg::dmc_wb_rsp_s              wb_rsp_o,
   input  wire logic                         row_step_pulse_i,
   input  wire logic                         row_stop_n_i,
   input  wire logic                         row_preset_n_i,
   output logic      [dmc_pkg::DOT_W-1:0]    dot_outputs_o,
   output logic                              dot_outputs_oe_o,
   output logic                              last_row_flag_o
);
   import dmc_pkg::*;

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   localparam int NSYNC = 3;
   logic [NSYNC-1:0] pins;
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;
   logic             step_dly_ff;
   logic             step_fall;
   logic             stop_s;
   logic             preset_s;

   assign pins = {row_preset_n_i, row_stop_n_i, row_step_pulse_i};

   // two stages per pin; only the second stage feeds logic
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               sync1_ff[gi] <= 1'b1;
               sync2_ff[gi] <= 1'b1;
            end else begin
               sync1_ff[gi] <= pins[gi];
               sync2_ff[gi] <= sync1_ff[gi];
            end
         end
      end
   endgenerate

   // falling edge of the step pulse is the counting moment
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_dly_ff <= 1'b1;
      end else begin
         step_dly_ff <= sync2_ff[0];
      end
   end

   assign step_fall = step_dly_ff && !sync2_ff[0];
   assign stop_s    = sync2_ff[1];
   assign preset_s  = sync2_ff[2];

   // ***************************************************************
   // software registers
   // ***************************************************************
   logic [9:0]         ctrl_ff;
   logic [CODE_W-1:0]  faddr_code_ff;
   logic [ROW_W-1:0]   faddr_row_ff;
   logic               bus_req;
   logic               wr_hit;
   logic               font_wr;
   logic [DOT_W-1:0]   bus_dots;
   logic [31:0]        nxt_rdata;
   dmc_wb_rsp_s        rsp_ff;

   assign bus_req = wb_req_i.cyc && wb_req_i.stb && !rsp_ff.ack;
   assign wr_hit  = bus_req && wb_req_i.we;
   assign font_wr = wr_hit && (wb_req_i.adr == ADR_FDATA)
                    && wb_req_i.sel[0];

   // ctrl register; byte lanes 0 and 1 written separately
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= CTRL_RESET;
      end else if (wr_hit && (wb_req_i.adr == ADR_CTRL)) begin
         if (wb_req_i.sel[0]) begin
            ctrl_ff[7:0] <= wb_req_i.dat[7:0];
         end
         if (wb_req_i.sel[1]) begin
            ctrl_ff[9:8] <= wb_req_i.dat[9:8];
         end
      end
   end

   // font pointer for loading a custom pattern
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         faddr_code_ff <= '0;
         faddr_row_ff  <= '0;
      end else if (wr_hit && (wb_req_i.adr == ADR_FADDR)) begin
         if (wb_req_i.sel[0]) begin
            faddr_code_ff <= wb_req_i.dat[FADDR_CODE_LSB +: CODE_W];
         end
         if (wb_req_i.sel[1]) begin
            faddr_row_ff <= wb_req_i.dat[FADDR_ROW_LSB +: ROW_W];
         end
      end
   end

   // ***************************************************************
   // row counter and last-row flag
   // ***************************************************************
   logic [ROW_W-1:0] row_ff;
   logic [ROW_W-1:0] nxt_row;
   logic             flag_ff;
   logic             nxt_flag;

   // preset is a level and acts without waiting for a step
   always_comb begin
      nxt_row = row_ff;
      if (!preset_s) begin
         nxt_row = ST_T7;
      end else if (step_fall) begin
         if (!stop_s && (row_ff == ST_END)) begin
            nxt_row = ST_END;
         end else begin
            nxt_row = row_ff + ROW_STEP;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         row_ff <= ST_END;
      end else begin
         row_ff <= nxt_row;
      end
   end

   // flag tracks entry to the last row and leaves on T1 or T7
   always_comb begin
      nxt_flag = flag_ff;
      if (nxt_row == ST_END) begin
         nxt_flag = 1'b1;
      end else if ((nxt_row == ST_T1) || (nxt_row == ST_T7)) begin
         nxt_flag = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_ff <= 1'b1;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   // ***************************************************************
   // display window and dot path
   // ***************************************************************
   logic [1:0]       mode;
   logic [ROW_W-1:0] win_first;
   logic [ROW_W-1:0] glyph_row;
   logic             in_win;
   logic             under_row;
   logic [DOT_W-1:0] mem_dots;
   logic [DOT_W-1:0] raw_dots;
   logic [DOT_W-1:0] dots_ff;
   logic             oe_ff;

   // mode is read live each cycle, so it may change with every code
   assign mode = {ctrl_ff[CTRL_SEL_A], ctrl_ff[CTRL_SEL_B]};

   always_comb begin
      case (mode)
         MODE_SUB:   win_first = WIN_SUB;
         MODE_SUPER: win_first = WIN_SUPER;
         default:    win_first = WIN_NORMAL;
      endcase
   end

   assign glyph_row = row_ff - win_first;
   assign in_win    = (row_ff >= win_first) && (glyph_row <= GLYPH_LAST);
   assign under_row = (mode == MODE_UNDER) && (row_ff == ST_UNDERLINE);

   dmc_glyph_mem u_mem (
      .clk_i      (clk_i),
      .wr_en_i    (font_wr),
      .wr_code_i  (faddr_code_ff),
      .wr_row_i   (faddr_row_ff),
      .wr_dots_i  (wb_req_i.dat[DOT_W-1:0]),
      .rd_code_i  (ctrl_ff[CTRL_CODE_LSB +: CODE_W]),
      .rd_row_i   (glyph_row),
      .rd_dots_o  (mem_dots),
      .bus_code_i (faddr_code_ff),
      .bus_row_i  (faddr_row_ff),
      .bus_dots_o (bus_dots)
   );

   // stored polarity: outline zero, field one
   always_comb begin
      if (under_row) begin
         raw_dots = DOTS_ZEROS;
      end else if (in_win) begin
         raw_dots = mem_dots;
      end else begin
         raw_dots = DOTS_ONES;
      end
   end

   // one register stage keeps the pins glitch free; one clock of latency
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dots_ff <= DOTS_ONES;
      end else if (ctrl_ff[CTRL_INVERT]) begin
         dots_ff <= raw_dots;
      end else begin
         dots_ff <= ~raw_dots;
      end
   end

   // enabling level is a build-time option of each part
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oe_ff <= 1'b0;
      end else begin
         oe_ff <= (ctrl_ff[CTRL_CE] == CE_ENABLE_LEVEL);
      end
   end

   assign dot_outputs_o    = dots_ff;
   assign dot_outputs_oe_o = oe_ff;
   assign last_row_flag_o  = flag_ff;

   // ***************************************************************
   // wishbone read data and acknowledge
   // ***************************************************************
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      case (wb_req_i.adr)
         ADR_CTRL: begin
            nxt_rdata[9:0] = ctrl_ff;
         end
         ADR_STATUS: begin
            nxt_rdata[STAT_ROW_LSB +: ROW_W] = row_ff;
            nxt_rdata[STAT_FLAG]             = flag_ff;
            nxt_rdata[STAT_OE]               = oe_ff;
            nxt_rdata[STAT_DOT_LSB +: DOT_W] = dots_ff;
         end
         ADR_FADDR: begin
            nxt_rdata[FADDR_CODE_LSB +: CODE_W] = faddr_code_ff;
            nxt_rdata[FADDR_ROW_LSB +: ROW_W]   = faddr_row_ff;
         end
         ADR_FDATA: begin
            nxt_rdata[DOT_W-1:0] = bus_dots;
         end
         default: begin
            nxt_rdata = 32'h0000_0000;
         end
      endcase
   end

   // every request is acked one cycle later, unmapped ones read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff.ack <= bus_req;
         rsp_ff.dat <= bus_req ? nxt_rdata : 32'h0000_0000;
      end
   end

   assign wb_rsp_o = rsp_ff;

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence bus_req_seq;
      wb_req_i.cyc && wb_req_i.stb && !rsp_ff.ack;
   endsequence

   sequence ack_pulse_seq;
      rsp_ff.ack ##1 !rsp_ff.ack;
   endsequence

   sequence free_wrap_seq;
      step_fall && preset_s && stop_s && (row_ff == ST_END);
   endsequence

   preset_force_a: assert property (
      !preset_s |=> (row_ff == ST_T7))
      else $error("preset did not force row seven");

   preset_prio_a: assert property (
      (!preset_s && !stop_s && step_fall) |=> (row_ff == ST_T7))
      else $error("stop overrode preset");

   stop_hold_a: assert property (
      (preset_s && !stop_s && (row_ff == ST_END)) |=> (row_ff == ST_END))
      else $error("counter left last row while stopped");

   free_wrap_a: assert property (
      free_wrap_seq |=> (row_ff == ST_T1))
      else $error("counter did not wrap to first row");

   step_count_a: assert property (
      (step_fall && preset_s && (row_ff != ST_END))
      |=> (row_ff == $past(row_ff) + ROW_STEP))
      else $error("counter did not advance by one");

   no_step_hold_a: assert property (
      (!step_fall && preset_s) |=> $stable(row_ff))
      else $error("counter moved without a falling step");

   flag_set_a: assert property (
      (row_ff == ST_END) |-> flag_ff)
      else $error("last-row flag low in last row");

   flag_clear_a: assert property (
      ((row_ff == ST_T1) || (row_ff == ST_T7)) |-> !flag_ff)
      else $error("last-row flag high in row one or seven");

   enable_level_a: assert property (
      1'b1 |=> (oe_ff == ($past(ctrl_ff[CTRL_CE]) == CE_ENABLE_LEVEL)))
      else $error("output enable does not follow chip enable");

   background_a: assert property (
      (!in_win && !under_row)
      |=> (dots_ff == ($past(ctrl_ff[CTRL_INVERT]) ? DOTS_ONES : DOTS_ZEROS)))
      else $error("dots not background outside window");

   bus_ack_a: assert property (
      bus_req_seq |=> ack_pulse_seq)
      else $error("bus ack is not a single cycle pulse");
endmodule // dmc_top
`default_nettype wire

// ==== tb/dmc_far_end.sv ====
// far-side model: row timing pins and the shared dot pins
`timescale 1ns/1ns
`default_nettype none
module dmc_far_end (
   input  wire logic       clk_i,
   input  wire logic [6:0] dots_i,
   input  wire logic       oe_i,
   output logic            step_o,
   output logic            stop_n_o,
   output logic            preset_n_o,
   output logic [6:0]      bus_o
);
   // released pins show the inverse, so a stale value never passes
   assign bus_o = oe_i ? dots_i : ~dots_i;

   // pins idle high, as the input pull-ups would leave them
   initial begin
      step_o = 1'b1;
      stop_n_o = 1'b1;
      preset_n_o = 1'b1;
   end

   // one row pulse; each level lasts well past the two-clock minimum
   task automatic step_row();
      @(posedge clk_i);
      step_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      step_o <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask

   // reset pins; waits out the pin synchroniser before returning
   task automatic set_pins(input logic stop_n, input logic preset_n);
      @(posedge clk_i);
      stop_n_o <= stop_n;
      preset_n_o <= preset_n;
      repeat (5) @(posedge clk_i);
   endtask
endmodule // dmc_far_end
`default_nettype wire

// ==== tb/dmc_top_test.sv ====
// self-checking bench for the character generator core
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   errors++; $display("Error at %0t: got %h expected %h", $time, g, e); \
   end end
module dmc_top_test;
   import dmc_pkg::*;
   logic             clk_i;
   logic             rst_i;
   dmc_wb_req_s      req;
   dmc_wb_rsp_s      rsp;
   logic             step;
   logic             stop_n;
   logic             preset_n;
   logic             oe;
   logic             flag;
   logic [DOT_W-1:0] dots;
   logic [DOT_W-1:0] bus;
   logic [31:0]      rd;
   int               errors;
   int               samples_checked;

   // 50 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   dmc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
      .wb_rsp_o(rsp), .row_step_pulse_i(step), .row_stop_n_i(stop_n),
      .row_preset_n_i(preset_n), .dot_outputs_o(dots),
      .dot_outputs_oe_o(oe), .last_row_flag_o(flag));

   dmc_far_end far (.clk_i(clk_i), .dots_i(dots), .oe_i(oe),
      .step_o(step), .stop_n_o(stop_n), .preset_n_o(preset_n),
      .bus_o(bus));

   // ***************************************************
   // bus cycles and expected values
   // ***************************************************
   // classic single cycle; a dead slave is left to the watchdog
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] wd);
      @(posedge clk_i);
      req <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hF, dat:wd};
      do begin
         @(posedge clk_i);
      end while (rsp.ack !== 1'b1);
      rd = rsp.dat;
      req <= '0;
   endtask

   // per code parity and glyph row a distinct pattern
   function automatic logic [6:0] pat(logic [5:0] c, logic [3:0] r);
      return {c[0], 2'b01, r};
   endfunction

   // window start per mode, underline at T13, background elsewhere
   function automatic logic [6:0] exp_dots(logic [1:0] m, logic [3:0] s,
                                           logic inv, logic [5:0] c);
      logic [3:0] f;
      logic [6:0] v;
      f = (m == MODE_SUB) ? 4'h6 : (m == MODE_SUPER) ? 4'h0 : 4'h3;
      v = 7'h7F;
      if (s >= f && s - f <= 4'h8) v = pat(c, s - f);
      else if (m == MODE_UNDER && s == 4'hC) v = 7'h00;
      return inv ? v : ~v;
   endfunction

   // ***************************************************
   // scenarios
   // ***************************************************
   // reset values, font load and read-back, unmapped address
   task automatic t_reset_font();
      wb(1'b0, ADR_STATUS, 32'h0);
      `CHK(rd[3:0], 4'hF)
      `CHK(rd[4], 1'b1)
      `CHK(oe, 1'b0)
      wb(1'b0, ADR_CTRL, 32'h0);
      `CHK(rd[9:0], CTRL_RESET)
      for (int k = 0; k < 18; k++) begin
         wb(1'b1, ADR_FADDR, {20'h0, 4'(k % 9), 2'b00,
                             (k < 9) ? 6'h2A : 6'h15});
         wb(1'b1, ADR_FDATA, {25'h0, pat((k < 9) ? 6'h2A : 6'h15,
                                         4'(k % 9))});
      end
      wb(1'b1, ADR_FADDR, 32'h0000_042A);
      wb(1'b0, ADR_FDATA, 32'h0);
      `CHK(rd[6:0], pat(6'h2A, 4'h4))
      wb(1'b0, 8'h10, 32'h0);
      `CHK(rd, 32'h0000_0000)
      $display("test reset_font done");
   endtask

   // preset to T7, then sixteen free-running steps with a wrap
   task automatic t_mode(input logic [1:0] m, input logic inv,
                         input logic [5:0] c);
      logic [3:0] s;
      wb(1'b1, ADR_CTRL, {22'h0, 1'b1, inv, m[0], m[1], c});
      far.set_pins(1'b1, 1'b0);
      far.set_pins(1'b1, 1'b1);
      s = 4'h6;
      for (int i = 0; i < 16; i++) begin
         wb(1'b0, ADR_STATUS, 32'h0);
         `CHK(rd[3:0], s)
         `CHK(flag, s == 4'hF)
         `CHK(dots, exp_dots(m, s, inv, c))
         `CHK(bus, dots)
         far.step_row();
         s = s + 4'h1;
      end
      $display("test mode %0d done", m);
   endtask

   // stop holds at last row, release gives T1, both low gives T7
   task automatic t_stop_preset();
      far.set_pins(1'b1, 1'b0);
      far.set_pins(1'b0, 1'b1);
      for (int i = 0; i < 12; i++) far.step_row();
      wb(1'b0, ADR_STATUS, 32'h0);
      `CHK(rd[4:0], 5'h1F)
      far.set_pins(1'b1, 1'b1);
      far.step_row();
      wb(1'b0, ADR_STATUS, 32'h0);
      `CHK(rd[4:0], 5'h00)
      far.set_pins(1'b0, 1'b0);
      far.step_row();
      wb(1'b0, ADR_STATUS, 32'h0);
      `CHK(rd[3:0], 4'h6)
      far.set_pins(1'b1, 1'b1);
      wb(1'b1, ADR_CTRL, 32'h0000_012A);
      repeat (2) @(posedge clk_i);
      `CHK(oe, 1'b0)
      `CHK(bus, ~dots)
      `CHK(flag, 1'b0)
      $display("test stop_preset done");
   endtask

   // end of run: counts and verdict
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // reset for three cycles, then the scenarios in turn
   initial begin
      errors = 0;
      samples_checked = 0;
      rst_i = 1'b1;
      req = '0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset_font();
      t_mode(MODE_NORMAL, 1'b1, 6'h2A);
      t_mode(MODE_UNDER, 1'b1, 6'h15);
      t_mode(MODE_SUB, 1'b0, 6'h2A);
      t_mode(MODE_SUPER, 1'b1, 6'h15);
      t_stop_preset();
      wrap_up();
   end

   // watchdog well past the expected run of about 1300 cycles
   initial begin
      repeat (30000) @(posedge clk_i);
      errors++;
      wrap_up();
   end
endmodule // dmc_top_test
`default_nettype wire
